//--- src/occ_engine.sv
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1 - pdu is loss-carrying only if both enables set and some loss counter non-zero or, on tx, the insert flag set
// R2 - with loss processing off, loss-carrying pdus are handled as plain ones
// R3 - with continuity processing off, pdus pass unmodified and checks are skipped
// R4 - per-type pdu count pulses and optional inclusion in loss data counters
// R5 - tx sequence rewritten with stored value when rewrite enabled
// R6 - stored tx sequence increments on every valid tx pdu while continuity processing is on
// R7 - tx remote defect bit replaced by configured value
// R8 - rx sets continuity flag, and loss flag for loss-carrying pdus
// R9 - sequence check against stored plus one, flag and count on mismatch, store
// R10 - remote defect change sets flag and interrupt, value stored
// R11 - valid rx clears the miss counter
// R12 - valid rx while loss status set raises change flag and clears status
// R13 - separate valid and invalid rx frame counters
// R14 - copy next pdu once, or all pdus per type, to the cpu
// R15 - record rx source port, member port when lag
// R16 - run count on same port, reset on change, stable flag at threshold
// R17 - status tlvs parsed only leading; other tlv stops parse, non-zero end
// R18 - parsed status tlv stored, change sets matching flag
// R19 - 3-bit miss counter steps on selected timer expiry
// R20 - miss count 7 sets loss status; each change sets flag
// R21 - insert flag turns next tx pdu into loss-carrying, then clears
// R22 - insert flag set by software or by selected timer expiry
// R23 - miss counter saturates at its maximum
module occ_engine
  import occ_pkg::*;
#(
  parameter int CNT_W  = 32,
  parameter int PORT_W = 8,
  parameter int NTIMER = 8
) (
  input  wire logic              clk_in,            // core clock 50 MHz
  input  wire logic              reset_in,          // sync reset, high
  input  wire logic              psel_in,           // apb select
  input  wire logic              penable_in,        // apb enable
  input  wire logic              pwrite_in,         // apb write
  input  wire logic [7:0]        paddr_in,          // apb byte address
  input  wire logic [31:0]       pwdata_in,         // apb write data
  output logic                   pready_out,        // apb ready
  output logic [31:0]            prdata_out,        // apb read data
  output logic                   pslverr_out,       // apb error
  input  wire logic              tx_valid_in,       // valid tx pdu strobe
  input  wire logic [31:0]       tx_seq_in,         // pdu sequence
  input  wire logic              tx_rdi_in,         // pdu remote defect
  input  wire logic              tx_lm_nz_in,       // loss counters non-zero
  output logic                   tx_done_out,       // tx result strobe
  output logic [31:0]            tx_seq_out,        // resulting sequence
  output logic                   tx_rdi_out,        // resulting remote defect
  output logic                   tx_lm_out,         // classed loss-carrying
  output logic                   tx_insert_out,     // write loss info now
  output logic                   tx_count_out,      // count in pdu counter
  output logic                   tx_data_count_out, // count in loss data
  input  wire logic              rx_valid_in,       // rx pdu strobe
  input  wire logic              rx_ok_in,          // generic validation ok
  input  wire logic [31:0]       rx_seq_in,         // pdu sequence
  input  wire logic              rx_rdi_in,         // pdu remote defect
  input  wire logic              rx_lm_nz_in,       // loss counters non-zero
  input  wire logic [PORT_W-1:0] rx_port_in,        // logical rx port
  input  wire logic              rx_is_lag_in,      // rx port is a lag
  input  wire logic [PORT_W-1:0] rx_member_in,      // lag member port
  input  wire logic [7:0]        rx_tlv0_type_in,   // first tlv type
  input  wire logic [7:0]        rx_tlv0_val_in,    // first tlv value
  input  wire logic [7:0]        rx_tlv1_type_in,   // second tlv type
  input  wire logic [7:0]        rx_tlv1_val_in,    // second tlv value
  output logic                   rx_done_out,       // rx result strobe
  output logic                   rx_lm_out,         // classed loss-carrying
  output logic                   rx_copy_out,       // copy to cpu
  output logic                   rx_tlv_nz_out,     // non-zero end tlv
  output logic                   rx_count_out,      // count in pdu counter
  output logic                   rx_data_count_out, // count in loss data
  input  wire logic [NTIMER-1:0] timer_expire_in,   // period timer pulses
  output logic                   irq_out            // enabled sticky flags
);

  typedef struct packed {
    logic [31:0]             ctrl;
    logic [31:0]             tx_seq;
    logic [31:0]             rx_seq;
    logic                    rx_rdi;
    logic                    loss;
    logic [2:0]              miss;
    logic [PORT_W-1:0]       last_port;
    logic [OCC_THRESH_W-1:0] run_cnt;
    logic [7:0]              port_state;
    logic [7:0]              if_state;
    logic [OCC_STICKY_W-1:0] sticky;
    logic [OCC_STICKY_W-1:0] irq_ena;
    logic                    copy_next;
    logic                    insert_next;
    logic [CNT_W-1:0]        vld_cnt;
    logic [CNT_W-1:0]        inv_cnt;
    logic [CNT_W-1:0]        err_cnt;
    logic [31:0]             prdata;
    logic                    tx_done;
    logic [31:0]             tx_seq_o;
    logic                    tx_rdi_o;
    logic                    tx_lm_o;
    logic                    tx_ins_o;
    logic                    tx_cnt_o;
    logic                    tx_dcnt_o;
    logic                    rx_done;
    logic                    rx_lm_o;
    logic                    rx_copy_o;
    logic                    rx_tlv_nz_o;
    logic                    rx_cnt_o;
    logic                    rx_dcnt_o;
  } occ_state_s;

  occ_state_s s_r;
  occ_state_s s_nxt;

  function automatic logic [CNT_W-1:0] occ_inc(input logic [CNT_W-1:0] v);
    occ_inc = v + {{(CNT_W-1){1'b0}}, 1'b1};
  endfunction

  function automatic logic occ_mapped(input logic [7:0] a);
    occ_mapped = (a <= OCC_ADDR_SEQ_ERR) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [31:0] occ_wide(input logic [CNT_W-1:0] v);
    occ_wide = 32'(v);
  endfunction

  logic apb_setup;
  logic apb_wr;
  logic cp_en;
  logic lm_en;
  logic [OCC_SEL_W-1:0] miss_sel;
  logic [OCC_SEL_W-1:0] ins_sel;
  logic [PORT_W-1:0]    src_port;

  assign apb_setup   = psel_in & ~penable_in;
  assign apb_wr      = psel_in & penable_in & pwrite_in & occ_mapped(paddr_in);
  assign pready_out  = psel_in & penable_in;
  assign pslverr_out = psel_in & penable_in & ~occ_mapped(paddr_in);
  assign cp_en       = s_r.ctrl[OCC_C_CP_ENA];
  assign lm_en       = s_r.ctrl[OCC_C_LM_ENA];
  assign miss_sel    = s_r.ctrl[OCC_C_MISS_SEL +: OCC_SEL_W];
  assign ins_sel     = s_r.ctrl[OCC_C_INS_SEL +: OCC_SEL_W];
  assign src_port    = rx_is_lag_in ? rx_member_in : rx_port_in; // R15

  always_comb begin
    logic [OCC_STICKY_W-1:0] set_m;
    logic [OCC_STICKY_W-1:0] clr_m;
    logic tx_lm;
    logic rx_lm;
    logic rx_good;
    logic t0p;
    logic t0i;
    logic t1p;
    logic t1i;
    s_nxt   = s_r;
    set_m   = '0;
    clr_m   = '0;
    tx_lm   = 1'b0;
    rx_lm   = 1'b0;
    rx_good = 1'b0;
    t0p     = 1'b0;
    t0i     = 1'b0;
    t1p     = 1'b0;
    t1i     = 1'b0;
    s_nxt.tx_done   = 1'b0;
    s_nxt.tx_cnt_o  = 1'b0;
    s_nxt.tx_dcnt_o = 1'b0;
    s_nxt.tx_ins_o  = 1'b0;
    s_nxt.rx_done   = 1'b0;
    s_nxt.rx_copy_o = 1'b0;
    s_nxt.rx_cnt_o  = 1'b0;
    s_nxt.rx_dcnt_o = 1'b0;
    s_nxt.rx_tlv_nz_o = 1'b0;
    s_nxt.rx_lm_o   = 1'b0;

    // apb read data captured in the setup phase
    if (apb_setup) begin
      case (paddr_in)
        OCC_ADDR_CTRL:    s_nxt.prdata = s_r.ctrl;
        OCC_ADDR_TX_SEQ:  s_nxt.prdata = s_r.tx_seq;
        OCC_ADDR_RX_SEQ:  s_nxt.prdata = s_r.rx_seq;
        OCC_ADDR_STATUS:  s_nxt.prdata = {8'h00, 8'(s_r.run_cnt), 8'(s_r.last_port),
                                          3'h0, s_r.miss, s_r.loss, s_r.rx_rdi};
        OCC_ADDR_TLV:     s_nxt.prdata = {16'h0000, s_r.if_state, s_r.port_state};
        OCC_ADDR_STICKY:  s_nxt.prdata = 32'(s_r.sticky);
        OCC_ADDR_IRQ_ENA: s_nxt.prdata = 32'(s_r.irq_ena);
        OCC_ADDR_CMD:     s_nxt.prdata = {30'h0, s_r.insert_next, s_r.copy_next};
        OCC_ADDR_RX_VLD:  s_nxt.prdata = occ_wide(s_r.vld_cnt);
        OCC_ADDR_RX_INV:  s_nxt.prdata = occ_wide(s_r.inv_cnt);
        OCC_ADDR_SEQ_ERR: s_nxt.prdata = occ_wide(s_r.err_cnt);
        default:          s_nxt.prdata = 32'h0000_0000;
      endcase
    end

    // tx path
    if (tx_valid_in) begin
      s_nxt.tx_done  = 1'b1;
      s_nxt.tx_seq_o = tx_seq_in;
      s_nxt.tx_rdi_o = tx_rdi_in;
      s_nxt.tx_lm_o  = 1'b0;
      if (cp_en) begin // R3
        tx_lm = lm_en & (tx_lm_nz_in | s_r.insert_next); // R1 R2
        s_nxt.tx_lm_o = tx_lm;
        if (s_r.ctrl[OCC_C_SEQ_UPD]) begin
          s_nxt.tx_seq_o = s_r.tx_seq; // R5
        end
        s_nxt.tx_seq   = s_r.tx_seq + 32'h0000_0001; // R6
        s_nxt.tx_rdi_o = s_r.ctrl[OCC_C_TX_RDI]; // R7
        if (s_r.insert_next && lm_en) begin
          s_nxt.tx_ins_o    = 1'b1; // R21
          s_nxt.insert_next = 1'b0; // R21
        end
      end
      s_nxt.tx_cnt_o  = tx_lm ? s_r.ctrl[OCC_C_LM_CNT_ENA] : s_r.ctrl[OCC_C_CNT_ENA]; // R4
      s_nxt.tx_dcnt_o = s_r.ctrl[OCC_C_DATA_ENA]; // R4
    end

    // miss counter on selected timer, saturating
    if (timer_expire_in[miss_sel] && s_r.miss != OCC_MISS_LOC && !(rx_valid_in && rx_ok_in && cp_en)) begin
      s_nxt.miss = s_r.miss + 3'h1; // R19 R23
    end
    if (s_nxt.miss == OCC_MISS_LOC && !s_r.loss) begin
      s_nxt.loss = 1'b1; // R20
      set_m[OCC_S_LOC_CHG] = 1'b1; // R20
    end

    // rx path
    if (rx_valid_in) begin
      s_nxt.rx_done = 1'b1;
      if (!rx_ok_in) begin
        s_nxt.inv_cnt = occ_inc(s_r.inv_cnt); // R13
      end else begin
        rx_good = 1'b1;
        s_nxt.vld_cnt = occ_inc(s_r.vld_cnt); // R13
      end
    end
    if (rx_good && cp_en) begin // R3
      rx_lm = lm_en & rx_lm_nz_in; // R1 R2
      s_nxt.rx_lm_o = rx_lm;
      set_m[OCC_S_CCM_RX] = 1'b1; // R8
      set_m[OCC_S_LM_RX]  = rx_lm; // R8
      if (s_r.ctrl[OCC_C_SEQ_CHK] && rx_seq_in != s_r.rx_seq + 32'h0000_0001) begin
        set_m[OCC_S_SEQ_ERR] = 1'b1; // R9
        s_nxt.err_cnt = occ_inc(s_r.err_cnt); // R9
      end
      s_nxt.rx_seq = rx_seq_in; // R9
      if (rx_rdi_in != s_r.rx_rdi) begin
        set_m[OCC_S_RDI_CHG] = 1'b1; // R10
      end
      s_nxt.rx_rdi = rx_rdi_in; // R10
      s_nxt.miss   = 3'h0; // R11
      if (s_r.loss) begin
        set_m[OCC_S_LOC_CHG] = 1'b1; // R12
      end
      s_nxt.loss = 1'b0; // R12
      s_nxt.rx_copy_o = s_r.copy_next |
                        (rx_lm ? s_r.ctrl[OCC_C_COPY_LM] : s_r.ctrl[OCC_C_COPY_ALL]); // R14
      s_nxt.copy_next = 1'b0; // R14
      // source move detection
      if (src_port == s_r.last_port) begin
        if (s_r.run_cnt != '1) begin
          s_nxt.run_cnt = s_r.run_cnt + 1'b1; // R16
        end
        if (s_nxt.run_cnt == s_r.ctrl[OCC_C_THRESH +: OCC_THRESH_W] && s_r.run_cnt != s_nxt.run_cnt) begin
          set_m[OCC_S_PORT_STBL] = 1'b1; // R16
        end
      end else begin
        s_nxt.run_cnt = '0; // R16
      end
      s_nxt.last_port = src_port; // R15
      // leading status tlvs, any order
      t0p = rx_tlv0_type_in == OCC_TLV_PORT; // R17
      t0i = rx_tlv0_type_in == OCC_TLV_IF; // R17
      t1p = (t0p | t0i) & ~t0p & (rx_tlv1_type_in == OCC_TLV_PORT); // R17
      t1i = (t0p | t0i) & ~t0i & (rx_tlv1_type_in == OCC_TLV_IF); // R17
      if (!(t0p | t0i)) begin
        s_nxt.rx_tlv_nz_o = rx_tlv0_type_in != OCC_TLV_END; // R17
      end else if (!(t1p | t1i)) begin
        s_nxt.rx_tlv_nz_o = rx_tlv1_type_in != OCC_TLV_END; // R17
      end
      set_m[OCC_S_TLV_NZ] = s_nxt.rx_tlv_nz_o;
      if (t0p | t1p) begin
        s_nxt.port_state = t0p ? rx_tlv0_val_in : rx_tlv1_val_in; // R18
        set_m[OCC_S_PORT_STATE] = s_nxt.port_state != s_r.port_state; // R18
      end
      if (t0i | t1i) begin
        s_nxt.if_state = t0i ? rx_tlv0_val_in : rx_tlv1_val_in; // R18
        set_m[OCC_S_IF_STATE] = s_nxt.if_state != s_r.if_state; // R18
      end
    end
    if (rx_good) begin
      s_nxt.rx_cnt_o  = rx_lm ? s_r.ctrl[OCC_C_LM_CNT_ENA] : s_r.ctrl[OCC_C_CNT_ENA]; // R4
      s_nxt.rx_dcnt_o = s_r.ctrl[OCC_C_DATA_ENA]; // R4
    end

    // software writes; hardware-set flags still win
    if (apb_wr) begin
      case (paddr_in)
        OCC_ADDR_CTRL:    s_nxt.ctrl = pwdata_in;
        OCC_ADDR_TX_SEQ:  s_nxt.tx_seq = pwdata_in;
        OCC_ADDR_RX_SEQ:  s_nxt.rx_seq = pwdata_in;
        OCC_ADDR_STICKY:  clr_m = pwdata_in[OCC_STICKY_W-1:0];
        OCC_ADDR_IRQ_ENA: s_nxt.irq_ena = pwdata_in[OCC_STICKY_W-1:0];
        OCC_ADDR_CMD: begin
          if (pwdata_in[OCC_CMD_COPY_NEXT]) begin
            s_nxt.copy_next = 1'b1; // R14
          end
          if (pwdata_in[OCC_CMD_INS_NEXT]) begin
            s_nxt.insert_next = 1'b1; // R22
          end
        end
        default: ;
      endcase
    end
    if (timer_expire_in[ins_sel]) begin
      s_nxt.insert_next = 1'b1; // R22
    end
    s_nxt.sticky = (s_r.sticky & ~clr_m) | set_m;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      s_r      <= '0;
      s_r.ctrl <= OCC_CTRL_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata_out        = s_r.prdata;
  assign tx_done_out       = s_r.tx_done;
  assign tx_seq_out        = s_r.tx_seq_o;
  assign tx_rdi_out        = s_r.tx_rdi_o;
  assign tx_lm_out         = s_r.tx_lm_o;
  assign tx_insert_out     = s_r.tx_ins_o;
  assign tx_count_out      = s_r.tx_cnt_o;
  assign tx_data_count_out = s_r.tx_dcnt_o;
  assign rx_done_out       = s_r.rx_done;
  assign rx_lm_out         = s_r.rx_lm_o;
  assign rx_copy_out       = s_r.rx_copy_o;
  assign rx_tlv_nz_out     = s_r.rx_tlv_nz_o;
  assign rx_count_out      = s_r.rx_cnt_o;
  assign rx_data_count_out = s_r.rx_dcnt_o;
  assign irq_out           = |(s_r.sticky & s_r.irq_ena); // R10 R12 R16 R18 R20

  // checks
  default clocking occ_cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  logic tx_seq_wr;
  assign tx_seq_wr = apb_wr && paddr_in == OCC_ADDR_TX_SEQ;

  chk_tx_seq_step: assert property (tx_valid_in && cp_en && !tx_seq_wr |=> s_r.tx_seq == $past(s_r.tx_seq) + 32'h1) // R6
    else $error("tx sequence did not step");
  chk_tx_seq_rewrite: assert property (tx_valid_in && cp_en && s_r.ctrl[OCC_C_SEQ_UPD] |=> tx_done_out && tx_seq_out == $past(s_r.tx_seq)) // R5
    else $error("tx sequence not rewritten");
  chk_tx_rdi_value: assert property (tx_valid_in && cp_en |=> tx_rdi_out == $past(s_r.ctrl[OCC_C_TX_RDI])) // R7
    else $error("tx remote defect not replaced");
  chk_tx_lm_class: assert property (tx_valid_in && !(cp_en && lm_en) |=> !tx_lm_out && !tx_insert_out) // R1
    else $error("loss class with processing off");
  chk_rx_miss_clear: assert property (rx_valid_in && rx_ok_in && cp_en |=> s_r.miss == 3'h0 && !s_r.loss) // R11
    else $error("miss counter not cleared");
  chk_loc_tracks_miss: assert property (s_r.loss == (s_r.miss == OCC_MISS_LOC)) // R20
    else $error("loss status disagrees with miss count");
  chk_miss_saturate: assert property (s_r.miss == OCC_MISS_LOC && !rx_valid_in |=> s_r.miss == OCC_MISS_LOC) // R23
    else $error("miss counter wrapped");
  chk_seq_err_flag: assert property (rx_valid_in && rx_ok_in && cp_en && s_r.ctrl[OCC_C_SEQ_CHK]
                                     && rx_seq_in != s_r.rx_seq + 32'h1
                                     |=> s_r.sticky[OCC_S_SEQ_ERR] && s_r.err_cnt == $past(s_r.err_cnt) + 1'b1) // R9
    else $error("sequence error missed");
  chk_rdi_change: assert property (rx_valid_in && rx_ok_in && cp_en && rx_rdi_in != s_r.rx_rdi
                                   |=> s_r.sticky[OCC_S_RDI_CHG] && s_r.rx_rdi == $past(rx_rdi_in)) // R10
    else $error("remote defect change missed");
  chk_insert_clear: assert property (tx_valid_in && cp_en && lm_en && s_r.insert_next && !timer_expire_in[ins_sel]
                                     && !apb_wr |=> tx_insert_out && tx_lm_out && !s_r.insert_next) // R21
    else $error("insert flag not consumed");

  cov_loss_entered: cover property (!s_r.loss ##1 s_r.loss);
  cov_rx_lm: cover property (rx_lm_out);
  cov_port_stable: cover property ($rose(s_r.sticky[OCC_S_PORT_STBL]));
  cov_tx_insert: cover property (tx_insert_out);
endmodule
`default_nettype wire

//--- include/occ_pkg.sv
package occ_pkg;
  // register byte addresses
  localparam logic [7:0] OCC_ADDR_CTRL    = 8'h00;
  localparam logic [7:0] OCC_ADDR_TX_SEQ  = 8'h04;
  localparam logic [7:0] OCC_ADDR_RX_SEQ  = 8'h08;
  localparam logic [7:0] OCC_ADDR_STATUS  = 8'h0C;
  localparam logic [7:0] OCC_ADDR_TLV     = 8'h10;
  localparam logic [7:0] OCC_ADDR_STICKY  = 8'h14;
  localparam logic [7:0] OCC_ADDR_IRQ_ENA = 8'h18;
  localparam logic [7:0] OCC_ADDR_CMD     = 8'h1C;
  localparam logic [7:0] OCC_ADDR_RX_VLD  = 8'h20;
  localparam logic [7:0] OCC_ADDR_RX_INV  = 8'h24;
  localparam logic [7:0] OCC_ADDR_SEQ_ERR = 8'h28;

  // control register fields
  localparam int OCC_C_CP_ENA     = 0;
  localparam int OCC_C_LM_ENA     = 1;
  localparam int OCC_C_CNT_ENA    = 2;
  localparam int OCC_C_LM_CNT_ENA = 3;
  localparam int OCC_C_DATA_ENA   = 4;
  localparam int OCC_C_SEQ_UPD    = 5;
  localparam int OCC_C_SEQ_CHK    = 6;
  localparam int OCC_C_COPY_ALL   = 7;
  localparam int OCC_C_COPY_LM    = 8;
  localparam int OCC_C_TX_RDI     = 9;
  localparam int OCC_C_MISS_SEL   = 12;
  localparam int OCC_C_INS_SEL    = 16;
  localparam int OCC_C_THRESH     = 24;
  localparam int OCC_SEL_W        = 3;
  localparam int OCC_THRESH_W     = 8;

  // sticky / irq enable bit positions
  localparam int OCC_S_CCM_RX     = 0;
  localparam int OCC_S_LM_RX      = 1;
  localparam int OCC_S_SEQ_ERR    = 2;
  localparam int OCC_S_RDI_CHG    = 3;
  localparam int OCC_S_LOC_CHG    = 4;
  localparam int OCC_S_PORT_STBL  = 5;
  localparam int OCC_S_PORT_STATE = 6;
  localparam int OCC_S_IF_STATE   = 7;
  localparam int OCC_S_TLV_NZ     = 8;
  localparam int OCC_STICKY_W     = 9;

  // command register bits
  localparam int OCC_CMD_COPY_NEXT = 0;
  localparam int OCC_CMD_INS_NEXT  = 1;

  // tlv type codes
  localparam logic [7:0] OCC_TLV_END  = 8'h00;
  localparam logic [7:0] OCC_TLV_PORT = 8'h02;
  localparam logic [7:0] OCC_TLV_IF   = 8'h04;

  localparam logic [2:0]  OCC_MISS_LOC   = 3'h7;
  localparam logic [31:0] OCC_CTRL_RESET = 32'h0000_0000;
endpackage

//--- sim/occ_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module occ_far_model #(
  parameter int PORT_W = 8,
  parameter int NTIMER = 8
) (
  input  wire logic         clk_in,           // core clock
  output logic              tx_valid_out,     // tx pdu strobe
  output logic [31:0]       tx_seq_out,       // tx sequence
  output logic              tx_rdi_out,       // tx remote defect
  output logic              tx_lm_nz_out,     // tx loss counters set
  output logic              rx_valid_out,     // rx pdu strobe
  output logic              rx_ok_out,        // rx validation ok
  output logic [31:0]       rx_seq_out,       // rx sequence
  output logic              rx_rdi_out,       // rx remote defect
  output logic              rx_lm_nz_out,     // rx loss counters set
  output logic [PORT_W-1:0] rx_port_out,      // logical port
  output logic              rx_is_lag_out,    // port is a lag
  output logic [PORT_W-1:0] rx_member_out,    // lag member
  output logic [7:0]        rx_t0_type_out,   // first tlv type
  output logic [7:0]        rx_t0_val_out,    // first tlv value
  output logic [7:0]        rx_t1_type_out,   // second tlv type
  output logic [7:0]        rx_t1_val_out,    // second tlv value
  output logic [NTIMER-1:0] timer_expire_out  // period timer pulses
);
  initial begin
    {tx_valid_out, tx_seq_out, tx_rdi_out, tx_lm_nz_out, rx_valid_out, rx_ok_out, rx_seq_out} = '0;
    {rx_rdi_out, rx_lm_nz_out, rx_port_out, rx_is_lag_out, rx_member_out, timer_expire_out} = '0;
    {rx_t0_type_out, rx_t0_val_out, rx_t1_type_out, rx_t1_val_out} = '0;
  end

  // released fields show the inverse of the last value
  task tx_pdu(input logic [31:0] s, input logic r, input logic z);
    @(posedge clk_in);
    {tx_valid_out, tx_seq_out, tx_rdi_out, tx_lm_nz_out} <= {1'b1, s, r, z};
    @(posedge clk_in);
    {tx_valid_out, tx_seq_out, tx_rdi_out, tx_lm_nz_out} <= {1'b0, ~s, ~r, ~z};
  endtask

  task rx_pdu(input logic o, input logic [31:0] s, input logic r, input logic z, input logic [PORT_W-1:0] p,
              input logic g, input logic [PORT_W-1:0] m, input logic [31:0] t);
    @(posedge clk_in);
    {rx_valid_out, rx_ok_out, rx_seq_out, rx_rdi_out, rx_lm_nz_out} <= {1'b1, o, s, r, z};
    {rx_port_out, rx_is_lag_out, rx_member_out} <= {p, g, m};
    {rx_t0_type_out, rx_t0_val_out, rx_t1_type_out, rx_t1_val_out} <= t;
    @(posedge clk_in);
    {rx_valid_out, rx_ok_out, rx_seq_out, rx_rdi_out, rx_lm_nz_out} <= {1'b0, ~o, ~s, ~r, ~z};
    {rx_port_out, rx_is_lag_out, rx_member_out} <= ~{p, g, m};
    {rx_t0_type_out, rx_t0_val_out, rx_t1_type_out, rx_t1_val_out} <= ~t;
  endtask

  task tick(input int i);
    @(posedge clk_in);
    timer_expire_out[i] <= 1'b1;
    @(posedge clk_in);
    timer_expire_out <= '0;
  endtask
endmodule
`default_nettype wire

//--- sim/test_oam_continuity_check_engine.sv
`timescale 1ns/1ps
`default_nettype none
module test_oam_continuity_check_engine import occ_pkg::*;;
  localparam logic [31:0] CP = 32'h1 << OCC_C_CP_ENA, LM = 32'h1 << OCC_C_LM_ENA, CN = 32'h1 << OCC_C_CNT_ENA;
  localparam logic [31:0] LC = 32'h1 << OCC_C_LM_CNT_ENA, DT = 32'h1 << OCC_C_DATA_ENA, SU = 32'h1 << OCC_C_SEQ_UPD;
  localparam logic [31:0] SC = 32'h1 << OCC_C_SEQ_CHK, CL = 32'h1 << OCC_C_COPY_LM, RD = 32'h1 << OCC_C_TX_RDI;
  logic        clk_in = 1'b0, reset_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, e;
  logic [7:0]  paddr_in, rx_port_in, rx_member_in, rx_tlv0_type_in, rx_tlv0_val_in, rx_tlv1_type_in;
  logic [7:0]  rx_tlv1_val_in, timer_expire_in;
  logic [31:0] pwdata_in, prdata_out, tx_seq_in, tx_seq_out, rx_seq_in, q;
  logic        pready_out, pslverr_out, tx_valid_in, tx_rdi_in, tx_lm_nz_in, tx_done_out, tx_rdi_out, tx_lm_out;
  logic        tx_insert_out, tx_count_out, tx_data_count_out, rx_valid_in, rx_ok_in, rx_rdi_in, rx_lm_nz_in;
  logic        rx_is_lag_in, rx_done_out, rx_lm_out, rx_copy_out, rx_tlv_nz_out, rx_count_out, rx_data_count_out, irq_out;
  int          bad_count = 0, n_compared = 0;

  always #10 clk_in = ~clk_in;

  occ_engine dut (.*);

  occ_far_model far (.clk_in, .tx_valid_out(tx_valid_in), .tx_seq_out(tx_seq_in), .tx_rdi_out(tx_rdi_in),
    .tx_lm_nz_out(tx_lm_nz_in), .rx_valid_out(rx_valid_in), .rx_ok_out(rx_ok_in), .rx_seq_out(rx_seq_in),
    .rx_rdi_out(rx_rdi_in), .rx_lm_nz_out(rx_lm_nz_in), .rx_port_out(rx_port_in), .rx_is_lag_out(rx_is_lag_in),
    .rx_member_out(rx_member_in), .rx_t0_type_out(rx_tlv0_type_in), .rx_t0_val_out(rx_tlv0_val_in),
    .rx_t1_type_out(rx_tlv1_type_in), .rx_t1_val_out(rx_tlv1_val_in), .timer_expire_out(timer_expire_in));

  task chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      bad_count++;
      $display("wrong value at %0t ns: got %h expected %h", $time, g, x);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    q = prdata_out;
    e = pslverr_out;
    {psel_in, penable_in} <= 2'b00;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q & m, x);
  endtask

  // flags: done, loss class, insert, count, data count, remote defect
  task txc(input logic [31:0] s, input logic r, input logic z, input logic [31:0] xs, input logic [5:0] xf);
    far.tx_pdu(s, r, z);
    #1;
    chk(tx_seq_out, xs);
    chk(32'({tx_done_out, tx_lm_out, tx_insert_out, tx_count_out, tx_data_count_out, tx_rdi_out}), 32'(xf));
  endtask

  // flags: done, loss class, copy, non-zero end, count, data count
  task rxc(input logic [31:0] s, input logic r, input logic z, input logic [7:0] p, input logic g,
           input logic [31:0] t, input logic [5:0] xf);
    far.rx_pdu(1'b1, s, r, z, p, g, p ^ 8'h04, t);
    #1;
    chk(32'({rx_done_out, rx_lm_out, rx_copy_out, rx_tlv_nz_out, rx_count_out, rx_data_count_out}), 32'(xf));
  endtask

  task test_done;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(OCC_ADDR_CTRL, '1, OCC_CTRL_RESET);
    rd(OCC_ADDR_STICKY, '1, 32'h0);
    apb(1'b0, 8'h2C, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    wr(OCC_ADDR_CTRL, CP | LM | CN | LC | DT | SU | RD);
    wr(OCC_ADDR_TX_SEQ, 32'h10);
    txc(32'h5, 1'b0, 1'b1, 32'h10, 6'b110111);
    txc(32'h5, 1'b0, 1'b0, 32'h11, 6'b100111);
    rd(OCC_ADDR_TX_SEQ, '1, 32'h12);
    wr(OCC_ADDR_CTRL, CP | CN | DT);
    txc(32'h77, 1'b1, 1'b1, 32'h77, 6'b100110);
    rd(OCC_ADDR_TX_SEQ, '1, 32'h13);
    wr(OCC_ADDR_CTRL, 32'h0);
    txc(32'h55, 1'b1, 1'b1, 32'h55, 6'b100001);
    rd(OCC_ADDR_TX_SEQ, '1, 32'h13);
    wr(OCC_ADDR_CTRL, CP | LM | LC | (32'h4 << OCC_C_INS_SEL));
    wr(OCC_ADDR_CMD, 32'h1 << OCC_CMD_INS_NEXT);
    txc(32'h1, 1'b0, 1'b0, 32'h1, 6'b111100);
    txc(32'h2, 1'b0, 1'b0, 32'h2, 6'b100000);
    far.tick(3);
    txc(32'h3, 1'b0, 1'b0, 32'h3, 6'b100000);
    far.tick(4);
    txc(32'h4, 1'b0, 1'b0, 32'h4, 6'b111100);
    wr(OCC_ADDR_CTRL, CP | LM | SC | (32'h2 << OCC_C_MISS_SEL) | (32'h2 << OCC_C_THRESH));
    wr(OCC_ADDR_RX_SEQ, 32'h20);
    wr(OCC_ADDR_IRQ_ENA, 32'h10);
    rxc(32'h21, 1'b1, 1'b1, 8'h03, 1'b0, 32'h0, 6'h30);
    rd(OCC_ADDR_STICKY, '1, 32'h00B);
    wr(OCC_ADDR_STICKY, 32'h1FF);
    rxc(32'h25, 1'b1, 1'b0, 8'h07, 1'b1, 32'h0, 6'h20);
    rd(OCC_ADDR_STICKY, '1, 32'h005);
    rd(OCC_ADDR_SEQ_ERR, '1, 32'h1);
    rd(OCC_ADDR_RX_SEQ, '1, 32'h25);
    wr(OCC_ADDR_STICKY, 32'h1FF);
    rxc(32'h26, 1'b0, 1'b0, 8'h03, 1'b0, 32'h0, 6'h20);
    rd(OCC_ADDR_STICKY, '1, 32'h029);
    rd(OCC_ADDR_STATUS, 32'h00FF_FF01, 32'h0002_0300);
    far.rx_pdu(1'b0, 32'h99, 1'b1, 1'b0, 8'h05, 1'b0, 8'h01, 32'h0);
    rd(OCC_ADDR_RX_INV, '1, 32'h1);
    rd(OCC_ADDR_RX_VLD, '1, 32'h3);
    wr(OCC_ADDR_STICKY, 32'h1FF);
    repeat (6) far.tick(2);
    far.tick(5);
    rd(OCC_ADDR_STATUS, 32'h1E, 32'h18);
    far.tick(2);
    rd(OCC_ADDR_STATUS, 32'h1E, 32'h1E);
    rd(OCC_ADDR_STICKY, '1, 32'h010);
    chk({31'h0, irq_out}, 32'h1);
    far.tick(2);
    rd(OCC_ADDR_STATUS, 32'h1E, 32'h1E);
    wr(OCC_ADDR_STICKY, 32'h1FF);
    #1;
    chk({31'h0, irq_out}, 32'h0);
    rxc(32'h27, 1'b0, 1'b0, 8'h03, 1'b0, 32'h0, 6'h20);
    rd(OCC_ADDR_STATUS, 32'h1E, 32'h0);
    rd(OCC_ADDR_STICKY, 32'h010, 32'h010);
    wr(OCC_ADDR_STICKY, 32'h1FF);
    rxc(32'h28, 1'b0, 1'b0, 8'h03, 1'b0, {OCC_TLV_IF, 8'h22, OCC_TLV_PORT, 8'h11}, 6'h20);
    rd(OCC_ADDR_TLV, '1, 32'h2211);
    rd(OCC_ADDR_STICKY, 32'h1C0, 32'h0C0);
    wr(OCC_ADDR_STICKY, 32'h1FF);
    rxc(32'h29, 1'b0, 1'b0, 8'h03, 1'b0, {8'h07, 8'h33, OCC_TLV_PORT, 8'h55}, 6'h24);
    rd(OCC_ADDR_TLV, '1, 32'h2211);
    rd(OCC_ADDR_STICKY, 32'h1C0, 32'h100);
    wr(OCC_ADDR_CMD, 32'h1 << OCC_CMD_COPY_NEXT);
    rxc(32'h2A, 1'b0, 1'b0, 8'h03, 1'b0, 32'h0, 6'h28);
    rxc(32'h2B, 1'b0, 1'b0, 8'h03, 1'b0, 32'h0, 6'h20);
    wr(OCC_ADDR_CTRL, CP | LM | CL | LC | DT);
    rxc(32'h2C, 1'b0, 1'b1, 8'h03, 1'b0, 32'h0, 6'h3B);
    rxc(32'h2D, 1'b0, 1'b0, 8'h03, 1'b0, 32'h0, 6'h21);
    wr(OCC_ADDR_CTRL, 32'h0);
    wr(OCC_ADDR_STICKY, 32'h1FF);
    rxc(32'h0, 1'b1, 1'b1, 8'h04, 1'b0, 32'h0, 6'h20);
    rd(OCC_ADDR_STICKY, '1, 32'h0);
    test_done();
  end
endmodule
`default_nettype wire
